// ---- wdg_chk_sva.sv ----
// assertion checker of the watchdog bus port and fault outputs
`timescale 1ns/10ps
`include "wdg_map.svh"
module wdg_chk #(
  parameter int AW = 12
)(
  input wire logic          ref_clk,
  input wire logic          rstn,
  input wire logic          bkup_rstn,
  input wire logic          psel,
  input wire logic          penable,
  input wire logic          pwrite,
  input wire logic [AW-1:0] paddr,
  input wire logic [31:0]   pwdata,
  input wire logic [31:0]   prdata,
  input wire logic          pready,
  input wire logic          pslverr,
  input wire logic          fault_req,
  input wire logic          reset_all_req,
  input wire logic          reset_proc_req
);
  // ****
  // access decode
  // ****
  wire acc   = psel && penable;
  wire st_rd = acc && !pwrite && paddr == `WDG_OFS_STATUS;
  wire cf_rd = acc && !pwrite && paddr == `WDG_OFS_CONFIG;
  wire bad_k = acc && pwrite && paddr == `WDG_OFS_RESTART && pwdata[31:24] != `WDG_KEY_VALUE;
  // either reset clears the counter, flags and fault (rstn keeps the reset enable), so both gate the checks
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rstn || !bkup_rstn);
  ready_zero_wait_a: assert property (pready == acc) else $error("pready not zero wait");
  unmapped_err_a: assert property (acc && paddr > `WDG_OFS_STATUS |-> pslverr) else $error("no unmapped error");
  mapped_ok_a: assert property (acc && paddr[1:0] == 2'h0 && paddr <= `WDG_OFS_STATUS |-> !pslverr)
    else $error("error on mapped offset");
  status_bits_a: assert property (st_rd |-> prdata[31:2] == 30'h0) else $error("status spare bits set");
  cfg_bits_a: assert property (cf_rd |-> prdata[31:30] == 2'h0) else $error("config spare bits set");
  req_excl_a: assert property (!(reset_all_req && reset_proc_req)) else $error("both resets asked");
  req_src_a: assert property (reset_all_req || reset_proc_req |-> fault_req) else $error("reset without fault");
  rd_clear_a: assert property (st_rd |=> !fault_req) else $error("fault kept after status read");
  key_guard_a: assert property (bad_k && !fault_req |=> !fault_req) else $error("bad key acted");
  cover property (st_rd && prdata[1:0] == 2'h2);
  cover property ($rose(reset_all_req));
  cover property ($rose(reset_proc_req));
endmodule // wdg_chk

bind wdg_top wdg_chk #(.AW(AW)) chk (.ref_clk(ref_clk), .rstn(rstn), .bkup_rstn(bkup_rstn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .fault_req(fault_req), .reset_all_req(reset_all_req), .reset_proc_req(reset_proc_req));

// ---- wdg_far_end.sv ----
// far-side model: free slow clock source and a reset controller counting requests
`timescale 1ns/10ps
module wdg_far_end #(
  parameter int HALF_NS = 170
)(
  input  wire logic       ref_clk,
  input  wire logic       reset_all_req,
  input  wire logic       reset_proc_req,
  output logic            slow_clk,
  output logic [7:0]      hits
);
  // ****
  // slow clock and reset requests
  // ****
  logic req_q = 1'b0;
  initial slow_clk = 1'b0;
  initial hits = 8'h00;
  // runs free and unrelated in phase to ref_clk
  always #(HALF_NS) slow_clk = ~slow_clk;
  // one count per new request, however long it is held
  always @(posedge ref_clk)
  begin
    req_q <= reset_all_req | reset_proc_req;
    if ((reset_all_req | reset_proc_req) && !req_q)
      hits <= hits + 8'h01;
  end
endmodule // wdg_far_end

// ---- wdg_map.svh ----
// register map, field positions, reset values and counts of the watchdog
`ifndef WDG_MAP_SVH
`define WDG_MAP_SVH

// ****************************************
// register offsets (byte addresses)
// ****************************************
`define WDG_OFS_RESTART 12'h000
`define WDG_OFS_CONFIG  12'h004
`define WDG_OFS_STATUS  12'h008

// ****************************************
// field positions
// ****************************************
`define WDG_KEY_HI      31
`define WDG_KEY_LO      24
`define WDG_KEY_VALUE   8'hA5
`define WDG_RESTART_BIT 0
`define WDG_LOAD_HI     11
`define WDG_LOAD_LO     0
`define WDG_FIEN_BIT    12
`define WDG_RSTEN_BIT   13
`define WDG_RPROC_BIT   14
`define WDG_OFF_BIT     15
`define WDG_DELTA_HI    27
`define WDG_DELTA_LO    16
`define WDG_DBGHLT_BIT  28
`define WDG_IDLEHLT_BIT 29
`define WDG_UNF_BIT     0
`define WDG_ERR_BIT     1

// ****************************************
// reset values and counts
// ****************************************
`define WDG_CONFIG_RST  32'h3FFF2FFF
`define WDG_CONFIG_MASK 32'h3FFFFFFF
`define WDG_PRESCALE    128

`endif

// ---- wdg_pkg.sv ----
// types shared by the watchdog modules
package wdg_pkg;

  // register selected by an apb address
  typedef enum logic [1:0] {
    WDG_SEL_RESTART,
    WDG_SEL_CONFIG,
    WDG_SEL_STATUS,
    WDG_SEL_NONE
  } wdg_sel_type;

  typedef logic [11:0] wdg_count_type;

endpackage

// ---- wdg_prescaler.sv ----
// divide-by-n prescaler turning slow clock edges into counter ticks
`timescale 1ns/10ps
module wdg_prescaler
  import wdg_pkg::*;
#(
  parameter int DIV = 128
)(
  input  wire logic ref_clk,
  input  wire logic rstn,
  input  wire logic slck_edge,
  input  wire logic run,
  input  wire logic clear,
  output logic      tick
);

  localparam int CW = $clog2(DIV);

  initial
  begin
    if (DIV < 2)
      $error("wdg_prescaler: DIV must be at least 2");
  end

  logic [CW-1:0] cnt_q;
  logic          tick_q;

  // clear wins over counting so a restart always gives a full period
  always_ff @(posedge ref_clk)
  begin
    if (!rstn || clear)
      cnt_q <= '0;
    else if (slck_edge && run)
    begin
      if (cnt_q == CW'(DIV - 1))
        cnt_q <= '0;
      else
        cnt_q <= cnt_q + 1'b1;
    end
  end

  // one-cycle tick in the cycle after the last slow edge of each period
  always_ff @(posedge ref_clk)
  begin
    if (!rstn || clear)
      tick_q <= 1'b0;
    else
      tick_q <= slck_edge && run && (cnt_q == CW'(DIV - 1));
  end

  assign tick = tick_q;

endmodule // wdg_prescaler

// ---- wdg_top.sv ----
// windowed watchdog timer with apb register access
// Notes on behaviour
// RL1 - twelve-bit down counter loaded from the load field of the config register
// RL2 - counter decrements on slow clock edges divided by 128
// RL3 - after processor reset the load field is 0xFFF and counting runs
// RL4 - fault reset enable reads one after a backup reset
// RL5 - config register takes only the first write after processor reset
// RL6 - writing config reloads the counter and restarts it
// RL7 - valid restart reloads the counter and clears the prescaler
// RL8 - restart command writes need key 0xA5 in the top byte
// RL9 - underflow sets its flag and, with fault reset enable, the fault output
// RL10 - restart is clean only while counter is at or below the window limit
// RL11 - early restart sets error flag and fault output, even when disabled
// RL12 - window limit at or above load value allows restart anytime
// RL13 - interrupt follows either flag when fault interrupt enable is set
// RL14 - watchdog reset clears the watchdog and both flags
// RL15 - status read clears flags, interrupt and fault output
// RL16 - processor-only select picks processor reset, else all resets
// RL17 - debug halt bit stops counting while processor is in debug
// RL18 - idle halt bit stops counting while system is idle
// RL19 - counter off bit disables the watchdog when one
// RL20 - config layout: load, four control bits, window limit, two halts
// RL21 - status has sticky underflow in bit 0, error in bit 1
// RL22 - disabled watchdog neither counts nor underflows; error check stays
`timescale 1ns/10ps
`include "wdg_map.svh"
module wdg_top
  import wdg_pkg::*;
#(
  parameter int AW       = 12,
  parameter int PRESCALE = `WDG_PRESCALE
)(
  input  wire logic          ref_clk,
  input  wire logic          rstn,
  input  wire logic          bkup_rstn,
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [AW-1:0] paddr,
  input  wire logic [31:0]   pwdata,
  output logic      [31:0]   prdata,
  output logic               pready,
  output logic               pslverr,
  input  wire logic          slow_clk,
  input  wire logic          debug_state,
  input  wire logic          idle_mode,
  output logic               fault_req,
  output logic               reset_all_req,
  output logic               reset_proc_req,
  output logic               fault_irq
);

  initial
  begin
    if (AW < 4)
      $error("wdg_top: AW must be at least 4");
    if (PRESCALE < 2)
      $error("wdg_top: PRESCALE must be at least 2");
  end

  // ****************************************
  // address decode
  // ****************************************

  // unmapped offsets answer with pslverr
  function automatic wdg_sel_type decode(input logic [AW-1:0] a);
    wdg_sel_type s;
    s = WDG_SEL_NONE;
    if (a == AW'(`WDG_OFS_RESTART))
      s = WDG_SEL_RESTART;
    else if (a == AW'(`WDG_OFS_CONFIG))
      s = WDG_SEL_CONFIG;
    else if (a == AW'(`WDG_OFS_STATUS))
      s = WDG_SEL_STATUS;
    return s;
  endfunction

  // ****************************************
  // state
  // ****************************************

  logic          sys_rstn;
  wdg_sel_type   sel;
  logic          access;
  logic          wr_cfg;
  logic          wr_rst;
  logic          rd_sts;
  logic          key_ok;
  logic          restart_req;
  logic          early;
  logic          tick;
  logic          running;
  logic          pre_clear;
  logic          unf_evt;
  logic          err_evt;
  logic [31:0]   cfg_view;
  logic [31:0]   prdata_q;
  logic [29:0]   cfg_q;
  logic          rsten_q;
  logic          cfg_locked_q;
  wdg_count_type cnt_q;
  wdg_count_type load_d;
  logic          unf_q;
  logic          err_q;
  logic          fault_q;
  logic          slck_s1_q;
  logic          slck_s2_q;
  logic          slck_s3_q;
  logic          slck_lvl_q;
  logic          slck_edge_q;

  // backup reset also resets the processor side
  assign sys_rstn = rstn && bkup_rstn;

  // ****************************************
  // apb slave
  // ****************************************

  assign sel    = decode(paddr);
  assign access = psel && penable;
  assign wr_cfg = access && pwrite && (sel == WDG_SEL_CONFIG);
  assign wr_rst = access && pwrite && (sel == WDG_SEL_RESTART);
  assign rd_sts = access && !pwrite && (sel == WDG_SEL_STATUS);

  // zero wait states: the read word is captured in the setup cycle
  assign pready  = access;
  assign pslverr = access && (sel == WDG_SEL_NONE);
  assign prdata  = prdata_q;

  // config readback merges the backup-held reset enable
  always_comb
  begin
    cfg_view = {2'b00, cfg_q};
    cfg_view[`WDG_RSTEN_BIT] = rsten_q; // RL4
  end

  // read word; restart command is write only and reads as zero
  always_ff @(posedge ref_clk)
  begin
    if (!sys_rstn)
      prdata_q <= 32'h0000_0000;
    else if (psel && !penable && !pwrite)
    begin
      unique case (sel)
        WDG_SEL_CONFIG:
          prdata_q <= cfg_view; // RL20
        WDG_SEL_STATUS:
          prdata_q <= {30'h0, err_q, unf_q}; // RL21
        WDG_SEL_RESTART,
        WDG_SEL_NONE:
          prdata_q <= 32'h0000_0000;
      endcase
    end
  end

  // ****************************************
  // config register, write once
  // ****************************************

  // reset value gives max load, window equal to load, counting on
  always_ff @(posedge ref_clk)
  begin
    if (!sys_rstn)
      cfg_q <= 30'(`WDG_CONFIG_RST); // RL3
    else if (wr_cfg && !cfg_locked_q)
      cfg_q <= 30'(pwdata & `WDG_CONFIG_MASK); // RL20
  end

  // lock is re-armed only by processor reset
  always_ff @(posedge ref_clk)
  begin
    if (!sys_rstn)
      cfg_locked_q <= 1'b0;
    else if (wr_cfg)
      cfg_locked_q <= 1'b1; // RL5
  end

  // reset enable lives in the backup domain; processor reset keeps it
  always_ff @(posedge ref_clk)
  begin
    if (!bkup_rstn)
      rsten_q <= 1'b1; // RL4
    else if (wr_cfg && !cfg_locked_q)
      rsten_q <= pwdata[`WDG_RSTEN_BIT];
  end

  // ****************************************
  // slow clock synchroniser
  // ****************************************

  // three stages; the level moves only once stages two and three agree
  always_ff @(posedge ref_clk)
  begin
    if (!sys_rstn)
    begin
      slck_s1_q <= 1'b0;
      slck_s2_q <= 1'b0;
      slck_s3_q <= 1'b0;
    end
    else
    begin
      slck_s1_q <= slow_clk;
      slck_s2_q <= slck_s1_q;
      slck_s3_q <= slck_s2_q;
    end
  end

  // filtered level and its rising edge
  always_ff @(posedge ref_clk)
  begin
    if (!sys_rstn)
    begin
      slck_lvl_q  <= 1'b0;
      slck_edge_q <= 1'b0;
    end
    else
    begin
      if (slck_s2_q == slck_s3_q)
        slck_lvl_q <= slck_s3_q;
      slck_edge_q <= (slck_s2_q == slck_s3_q) && slck_s3_q && !slck_lvl_q;
    end
  end

  // ****************************************
  // prescaler and run gating
  // ****************************************

  // disabled or halted watchdog freezes the prescaler as well
  assign running = !cfg_q[`WDG_OFF_BIT] // RL19 RL22
    && !(cfg_q[`WDG_DBGHLT_BIT] && debug_state) // RL17
    && !(cfg_q[`WDG_IDLEHLT_BIT] && idle_mode); // RL18

  // restart and config write both restart the divider
  assign pre_clear = restart_req || (wr_cfg && !cfg_locked_q); // RL7 RL6

  wdg_prescaler #(
    .DIV (PRESCALE)
  ) u_prescaler (
    .ref_clk   (ref_clk),
    .rstn      (sys_rstn),
    .slck_edge (slck_edge_q),
    .run       (running),
    .clear     (pre_clear),
    .tick      (tick)
  );

  // ****************************************
  // restart command
  // ****************************************

  assign key_ok      = pwdata[`WDG_KEY_HI:`WDG_KEY_LO] == `WDG_KEY_VALUE; // RL8
  assign restart_req = wr_rst && key_ok && pwdata[`WDG_RESTART_BIT];

  // outside the window the restart is refused; limit >= load never trips
  assign early   = restart_req
    && (cnt_q > cfg_q[`WDG_DELTA_HI:`WDG_DELTA_LO]); // RL10 RL12
  assign err_evt = early; // RL11

  // ****************************************
  // down counter
  // ****************************************

  // new load value comes from the write data on a config write
  assign load_d = (wr_cfg && !cfg_locked_q)
    ? pwdata[`WDG_LOAD_HI:`WDG_LOAD_LO]
    : cfg_q[`WDG_LOAD_HI:`WDG_LOAD_LO];

  assign unf_evt = tick && running && (cnt_q == 12'h000); // RL9 RL22

  // reload on config write, clean restart or underflow; else count down
  always_ff @(posedge ref_clk)
  begin
    if (!sys_rstn)
      cnt_q <= 12'(`WDG_CONFIG_RST); // RL3 RL14
    else if (wr_cfg && !cfg_locked_q)
      cnt_q <= load_d; // RL6
    else if (restart_req && !early)
      cnt_q <= load_d; // RL7
    else if (unf_evt)
      cnt_q <= load_d;
    else if (tick && running)
      cnt_q <= cnt_q - 12'h001; // RL1 RL2
  end

  // ****************************************
  // status flags and fault
  // ****************************************

  // the read word is captured one cycle before the access edge, so a read
  // clears only the flags that it reported; an event that lands between the
  // setup and access edges stays pending instead of being lost unseen
  // sticky underflow; a new event beats the read that clears it
  always_ff @(posedge ref_clk)
  begin
    if (!sys_rstn)
      unf_q <= 1'b0; // RL14
    else if (unf_evt)
      unf_q <= 1'b1; // RL9 RL21
    else if (rd_sts && prdata_q[`WDG_UNF_BIT])
      unf_q <= 1'b0; // RL15
  end

  // sticky early restart error, checked even when disabled
  always_ff @(posedge ref_clk)
  begin
    if (!sys_rstn)
      err_q <= 1'b0; // RL14
    else if (err_evt)
      err_q <= 1'b1; // RL11 RL21
    else if (rd_sts && prdata_q[`WDG_ERR_BIT])
      err_q <= 1'b0; // RL15
  end

  // fault to the reset controller; early restart raises it regardless
  always_ff @(posedge ref_clk)
  begin
    if (!sys_rstn)
      fault_q <= 1'b0;
    else if ((unf_evt && rsten_q) || err_evt)
      fault_q <= 1'b1; // RL9 RL11
    else if (rd_sts)
      fault_q <= 1'b0; // RL15
  end

  // ****************************************
  // outputs to reset controller and interrupt
  // ****************************************

  assign fault_req = fault_q;

  // reset requests only when the fault is allowed to reset
  assign reset_proc_req = fault_q && rsten_q && cfg_q[`WDG_RPROC_BIT]; // RL16
  assign reset_all_req  = fault_q && rsten_q && !cfg_q[`WDG_RPROC_BIT]; // RL16

  // interrupt level clears with the flags on a status read
  assign fault_irq = cfg_q[`WDG_FIEN_BIT] && (unf_q || err_q); // RL13

endmodule // wdg_top

// ---- windowed_watchdog_timer_tb.sv ----
// self-checking bench of the windowed watchdog
`timescale 1ns/10ps
`include "wdg_map.svh"
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin errors++; $display("MISMATCH %s exp %h got %h", nm, e, g); end end
module windowed_watchdog_timer_tb;
  logic        ref_clk = '0, rstn = '0, bkup_rstn = '0, psel = '0, penable = '0, pwrite = '0;
  logic        debug_state = '0, idle_mode = '0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata;
  logic        pready, pslverr, slow_clk, fault_req, reset_all_req, reset_proc_req, fault_irq;
  logic [7:0]  hits, k;
  logic [32:0] exp_q[$], exp_r;
  int          errors = 0, cmp_count = 0, n, seed = 32'h2D96055E;
  localparam logic [31:0] RCMD = 32'hA5000001;
  // ****
  // clock, design and far side
  // ****
  always #25 ref_clk = ~ref_clk;
  wdg_top #(.PRESCALE(2)) dut (.ref_clk(ref_clk), .rstn(rstn), .bkup_rstn(bkup_rstn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .slow_clk(slow_clk), .debug_state(debug_state), .idle_mode(idle_mode),
    .fault_req(fault_req), .reset_all_req(reset_all_req), .reset_proc_req(reset_proc_req), .fault_irq(fault_irq));
  wdg_far_end far (.ref_clk(ref_clk), .reset_all_req(reset_all_req), .reset_proc_req(reset_proc_req),
    .slow_clk(slow_clk), .hits(hits));
  task automatic give_verdict;
    $display("errors %0d compares %0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // apb transfer; read expectations hold {pslverr, prdata}
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic [32:0] e);
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    if (!wr)
      exp_q.push_back(e);
    @(posedge ref_clk);
    penable <= 1'b1;
    // only the watchdog process ends a wait that never sees pready
    do @(posedge ref_clk); while (!pready);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [32:0] e);
    apb(1'b0, a, 32'h0, e);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 33'h0);
  endtask
  // rstn always; the backup domain only when asked
  task automatic rst(input logic bk);
    rstn <= 1'b0;
    bkup_rstn <= !bk;
    repeat (20) @(posedge ref_clk);
    rstn <= 1'b1;
    bkup_rstn <= 1'b1;
  endtask
  // compares each completed read with the oldest note
  always @(posedge ref_clk)
    if (psel && penable && pready && !pwrite)
    begin
      exp_r = exp_q.pop_front();
      `CHK("read", exp_r, {pslverr, prdata})
    end
  // ****
  // scenarios
  // ****
  initial
  begin
    rst(1'b1);
    rd(12'h004, {1'b0, `WDG_CONFIG_RST});
    rd(12'h008, 33'h0);
    rd(12'h00C, 33'h100000000);
    wr(12'h000, RCMD);
    k = $random(seed);
    wr(12'h000, {(k == 8'hA5) ? 8'h5A : k, 24'h000001});
    rd(12'h008, 33'h0);
    // load 0x10, window 4, irq, reset enable, processor only
    wr(12'h004, 32'h00047010);
    wr(12'h004, 32'h00008FFF);
    rd(12'h004, 33'h00047010);
    wr(12'h000, RCMD);
    @(posedge ref_clk);
    `CHK("proc", 1'b1, reset_proc_req)
    `CHK("irq", 1'b1, fault_irq)
    rd(12'h008, 33'h2);
    @(posedge ref_clk);
    `CHK("irq", 1'b0, fault_irq)
    n = 0;
    while (!fault_irq && n < 2000)
    begin
      @(posedge ref_clk);
      n++;
    end
    `CHK("span", 1'b1, n > 100)
    `CHK("proc", 1'b1, reset_proc_req)
    rd(12'h008, 33'h1);
    rst(1'b0);
    rd(12'h004, {1'b0, `WDG_CONFIG_RST});
    // off, reset all, load 0x20, window 1
    wr(12'h004, 32'h0001A020);
    repeat (300) @(posedge ref_clk);
    rd(12'h008, 33'h0);
    wr(12'h000, RCMD);
    @(posedge ref_clk);
    `CHK("all", 1'b1, reset_all_req)
    `CHK("fault", 1'b1, fault_req)
    rd(12'h008, 33'h2);
    for (int i = 0; i < 2; i++)
    begin
      rst(1'b0);
      rd(12'h008, 33'h0);
      debug_state <= (i == 0);
      idle_mode <= (i == 1);
      wr(12'h004, 32'h0FFF1004 | (32'h10000000 << i));
      repeat (300) @(posedge ref_clk);
      rd(12'h008, 33'h0);
      debug_state <= 1'b0;
      idle_mode <= 1'b0;
      repeat (300) @(posedge ref_clk);
      rd(12'h008, 33'h1);
      // let a further underflow land so that the next reset has flags to clear
      repeat (100) @(posedge ref_clk);
      `CHK("irq", 1'b1, fault_irq)
      `CHK("fault", 1'b0, fault_req)
    end
    // processor reset keeps the backup-held reset enable, backup reset sets it
    rst(1'b0);
    rd(12'h004, 33'h03FFF0FFF);
    rst(1'b1);
    rd(12'h004, {1'b0, `WDG_CONFIG_RST});
    `CHK("hits", 8'h03, hits)
    give_verdict();
  end
  // cuts a hang short well past the expected run length
  initial
  begin
    repeat (20000) @(posedge ref_clk);
    errors++;
    give_verdict();
  end
endmodule // windowed_watchdog_timer_tb
